//--- design/pwc_defs.svh
// Register map, field positions, reset values and timing figures of the power controller
`ifndef PWC_DEFS_SVH
`define PWC_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PWC_REG_CTRL 8'h00
`define PWC_REG_WAKE_EN 8'h04
`define PWC_REG_STATUS 8'h08
`define PWC_REG_CAUSE 8'h0c
`define PWC_REG_LAT 8'h10

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define PWC_CTRL_CMD_HI 2
`define PWC_CTRL_SUP_BIT 3
`define PWC_CTRL_SLEEP_DONE_BIT 4
`define PWC_WAKE_EN_RST 23'h000000

// ----------------------------------------
// Wakeup source classes
// ----------------------------------------
`define PWC_NSRC 23
`define PWC_SRC_ALWAYS 23'h0003ef
`define PWC_SRC_LOWPWR 23'h3ffc10
`define PWC_SRC_VIC 23'h400000

// ----------------------------------------
// Clock ceilings in MHz
// ----------------------------------------
`define PWC_CEIL_FULL 8'd180
`define PWC_CEIL_RED 8'd90
`define PWC_CEIL_LOW_LDO 8'd20
`define PWC_CEIL_LOW_SCC 8'd32

// ----------------------------------------
// SRAM modes
// ----------------------------------------
`define PWC_SRAM_OFF 2'b00
`define PWC_SRAM_RETAIN 2'b01
`define PWC_SRAM_ACTIVE 2'b10

// ----------------------------------------
// Timing
// ----------------------------------------
`define PWC_CLK_MHZ 125
`define PWC_LAT_FULL_US 1200
`define PWC_LAT_LOW_US 200
`define PWC_LAT_FULL_CYC (`PWC_LAT_FULL_US * `PWC_CLK_MHZ)
`define PWC_LAT_LOW_CYC (`PWC_LAT_LOW_US * `PWC_CLK_MHZ)

`endif

//--- design/pwc_pkg.sv
// Types shared by the power controller
package pwc_pkg;

	// Gray steps along active -> low -> off -> standby -> sleep -> resume
	typedef enum logic [3:0] {
		ST_FULL = 4'h0,
		ST_RED = 4'h1,
		ST_LOW = 4'h3,
		ST_CPU_OFF = 4'h2,
		ST_LOW_SB = 4'h6,
		ST_LOW_SL = 4'h7,
		ST_RESUME = 4'h5,
		ST_FULL_SB = 4'h4,
		ST_RED_SB = 4'hc,
		ST_FULL_SL = 4'hd,
		ST_RED_SL = 4'hf,
		ST_SHUT = 4'he
	} pwc_state_type;

	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_FULL = 3'h1,
		CMD_RED = 3'h2,
		CMD_LOW = 3'h3,
		CMD_SLEEP = 3'h4,
		CMD_CPU_OFF = 3'h5,
		CMD_SHUT = 3'h6
	} pwc_cmd_type;

endpackage

//--- design/pwc_top.sv
// Power-state sequencer and wakeup controller of the application processor subsystem
//
// Function
// - Full-performance active allows at most 180 MHz from the fast PLL.
// - Full-performance active powers all groups, all GPIOs and all SRAM.
// - Reduced-voltage active matches full-performance but caps the clock at 90 MHz.
// - Low-voltage ceiling is 20 MHz on the regulator, 32 MHz on converter.
// - Low-voltage active clocks the processor from the low-power bus clock.
// - Low-voltage active keeps low-power, debug/FPU/ROM, battery, analog groups and 13 GPIOs only.
// - Report resume latency: 1200 us for full, 200 us for low-voltage.
// - Processor-off entered only from low-voltage by software; processor power-gated.
// - In processor-off a peripheral interrupt wakes or triggers sleep.
// - Processor-off retains main SRAM and keeps low-power SRAM active.
// - Standby entered from its active state by wait-for-interrupt; clock gated only.
// - Full and reduced standby accept any vectored interrupt line as wakeup.
// - Sleep entered by software from matching active; battery, analog, 3 GPIOs stay.
// - Return from sleep restores all peripheral configuration to defaults.
// - Shutdown entered only from full-performance by software; only battery, analog and 3 GPIOs remain.
// - Sleep and processor-off retain all SRAM and backup; shutdown only backup.
// - Common wakeup sources accepted in every standby, sleep, off, shutdown state.
// - Low-power group wakeups only in low-voltage standby and processor-off.
// - Reset leaves the subsystem in full-performance active.
// - Active to standby or sleep only on software request.
// - Only software-enabled sources cause a wakeup.
// - Wakeup returns to the active state the low-power state came from.
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`include "pwc_defs.svh"

module pwc_top import pwc_pkg::*; #(
	parameter int RESUME_FULL_CYC = `PWC_LAT_FULL_CYC,
	parameter int RESUME_LOW_CYC = `PWC_LAT_LOW_CYC
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Register port
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// Processor and wakeup sources
	input wire logic WAIT_FOR_INTERRUPT_INSTRUCTION,
	input wire logic [`PWC_NSRC-1:0] WAKE_SRC,
	// Clock and power controls
	output logic [7:0] CLK_CEIL_MHZ,
	output logic CLK_SEL_PLL,
	output logic CPU_CLK_EN,
	output logic CPU_PWR_EN,
	output logic HP_PERIPH_PWR,
	output logic ULP_PERIPH_PWR,
	output logic BATT_PERIPH_PWR,
	output logic ANALOG_PWR,
	output logic HS_IF_PWR,
	output logic DBG_FPU_ROM_PWR,
	output logic INSTRUCTION_CACHE_PWR,
	output logic [2:0] GPIO_EN,
	output logic [1:0] MAIN_SRAM_MODE,
	output logic [1:0] LOW_POWER_SRAM_MODE,
	output logic BACKUP_RETAIN,
	output logic PERIPH_CFG_RST,
	output logic [3:0] STATE
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	pwc_state_type state_q, state_d, ret_q, ret_d;
	logic [17:0] cnt_q, cnt_d;
	logic sup_q, sleep_done_q, cfg_rst_d;
	logic [`PWC_NSRC-1:0] wake_en_q, cause_q, allow, hit;
	pwc_cmd_type cmd;
	logic wr_ctrl;

	assign wr_ctrl = WR && (ADDR == `PWC_REG_CTRL);
	assign cmd = pwc_cmd_type'(WDATA[`PWC_CTRL_CMD_HI:0]);

	always_ff @(posedge CLK) begin
		if (RST) begin
			sup_q <= 1'b0;
			sleep_done_q <= 1'b0;
		end else if (wr_ctrl) begin
			sup_q <= WDATA[`PWC_CTRL_SUP_BIT];
			sleep_done_q <= WDATA[`PWC_CTRL_SLEEP_DONE_BIT];
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			wake_en_q <= `PWC_WAKE_EN_RST;
		end else if (WR && ADDR == `PWC_REG_WAKE_EN) begin
			wake_en_q <= WDATA[`PWC_NSRC-1:0];
		end
	end

	// ----------------------------------------
	// Wakeup gating
	// ----------------------------------------
	always_comb begin
		unique case (state_q)
			ST_FULL_SB, ST_RED_SB: allow = `PWC_SRC_ALWAYS | `PWC_SRC_VIC;
			ST_LOW_SB, ST_CPU_OFF: allow = `PWC_SRC_ALWAYS | `PWC_SRC_LOWPWR;
			ST_FULL_SL, ST_RED_SL, ST_LOW_SL, ST_SHUT: allow = `PWC_SRC_ALWAYS;
			default: allow = '0;
		endcase
	end

	assign hit = WAKE_SRC & wake_en_q & allow;

	// New wakeup sets win over a clear in the same cycle
	always_ff @(posedge CLK) begin
		if (RST) begin
			cause_q <= '0;
		end else begin
			cause_q <= hit | (cause_q & ~((WR && ADDR == `PWC_REG_CAUSE) ?
				WDATA[`PWC_NSRC-1:0] : '0));
		end
	end

	// ----------------------------------------
	// State sequencing
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		ret_d = ret_q;
		cnt_d = cnt_q;
		cfg_rst_d = 1'b0;
		unique case (state_q)
			ST_FULL, ST_RED, ST_LOW: begin
				if (wr_ctrl) begin
					// only software or WAIT_FOR_INTERRUPT_INSTRUCTION leaves an active state
					unique case (cmd)
						CMD_FULL: state_d = ST_FULL;
						CMD_RED: state_d = ST_RED;
						CMD_LOW: state_d = ST_LOW;
						CMD_SLEEP: state_d = (state_q == ST_FULL) ? ST_FULL_SL :
							(state_q == ST_RED) ? ST_RED_SL : ST_LOW_SL;
						CMD_CPU_OFF: if (state_q == ST_LOW) state_d = ST_CPU_OFF;
						CMD_SHUT: if (state_q == ST_FULL) state_d = ST_SHUT;
						default: state_d = state_q;
					endcase
				end else if (WAIT_FOR_INTERRUPT_INSTRUCTION) begin
					state_d = (state_q == ST_FULL) ? ST_FULL_SB :
						(state_q == ST_RED) ? ST_RED_SB : ST_LOW_SB;
				end
				ret_d = state_d == ST_SHUT ? ST_FULL : state_q;
			end
			ST_FULL_SB, ST_RED_SB, ST_LOW_SB: begin
				// Clock was only gated, so the processor resumes at once
				if (|hit) state_d = ret_q;
			end
			ST_CPU_OFF: begin
				if (|(hit & `PWC_SRC_LOWPWR) && sleep_done_q) begin
					state_d = ST_LOW_SL;
				end else if (|hit) begin
					state_d = ST_RESUME;
					cnt_d = 18'(RESUME_LOW_CYC - 1);
				end
			end
			ST_FULL_SL, ST_RED_SL, ST_LOW_SL, ST_SHUT: begin
				if (|hit) begin
					state_d = ST_RESUME;
					cfg_rst_d = 1'b1;
					cnt_d = 18'((ret_q == ST_LOW ? RESUME_LOW_CYC : RESUME_FULL_CYC) - 1);
				end
			end
			ST_RESUME: begin
				if (cnt_q == '0) state_d = ret_q;
				else cnt_d = cnt_q - 18'd1;
			end
			default: state_d = ST_FULL;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state_q <= ST_FULL;
			ret_q <= ST_FULL;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			ret_q <= ret_d;
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------
	// Resource controls
	// ----------------------------------------
	pwc_state_type view;
	logic [7:0] ceil_d;
	logic pll_d, clk_en_d, pwr_d, hp_d, ulp_d, hs_d, ic_d, dbg_d, batt_d;
	logic [2:0] gpio_d;
	logic [1:0] main_d, lp_d;

	// While resuming, the target's supplies come up but the clock stays gated
	assign view = (state_q == ST_RESUME) ? ret_q : state_q;

	always_comb begin
		ceil_d = '0;
		pll_d = 1'b0;
		clk_en_d = 1'b0;
		pwr_d = 1'b0;
		hp_d = 1'b0;
		ulp_d = 1'b0;
		hs_d = 1'b0;
		ic_d = 1'b0;
		dbg_d = 1'b0;
		batt_d = 1'b1;
		gpio_d = 3'b001;
		main_d = `PWC_SRAM_RETAIN;
		lp_d = `PWC_SRAM_RETAIN;
		unique case (view)
			ST_FULL, ST_RED, ST_FULL_SB, ST_RED_SB: begin
				ceil_d = (view == ST_FULL || view == ST_FULL_SB) ?
					`PWC_CEIL_FULL : `PWC_CEIL_RED;
				pll_d = 1'b1;
				pwr_d = 1'b1;
				hp_d = 1'b1;
				ulp_d = 1'b1;
				hs_d = 1'b1;
				ic_d = 1'b1;
				dbg_d = 1'b1;
				gpio_d = 3'b111;
				main_d = `PWC_SRAM_ACTIVE;
				lp_d = `PWC_SRAM_ACTIVE;
			end
			ST_LOW, ST_LOW_SB: begin
				ceil_d = sup_q ? `PWC_CEIL_LOW_SCC : `PWC_CEIL_LOW_LDO;
				pwr_d = 1'b1;
				ulp_d = 1'b1;
				dbg_d = 1'b1;
				gpio_d = 3'b011;
				main_d = `PWC_SRAM_ACTIVE;
				lp_d = `PWC_SRAM_ACTIVE;
			end
			ST_CPU_OFF: begin
				ulp_d = 1'b1;
				gpio_d = 3'b011;
				lp_d = `PWC_SRAM_ACTIVE;
			end
			ST_SHUT: begin
				main_d = `PWC_SRAM_OFF;
				lp_d = `PWC_SRAM_OFF;
			end
			default: batt_d = 1'b1;
		endcase
		clk_en_d = (state_q == ST_FULL || state_q == ST_RED || state_q == ST_LOW);
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			CLK_CEIL_MHZ <= `PWC_CEIL_FULL;
			CLK_SEL_PLL <= 1'b1;
			CPU_CLK_EN <= 1'b0;
			CPU_PWR_EN <= 1'b1;
			HP_PERIPH_PWR <= 1'b1;
			ULP_PERIPH_PWR <= 1'b1;
			HS_IF_PWR <= 1'b1;
			INSTRUCTION_CACHE_PWR <= 1'b1;
			DBG_FPU_ROM_PWR <= 1'b1;
			BATT_PERIPH_PWR <= 1'b1;
			ANALOG_PWR <= 1'b1;
			GPIO_EN <= 3'b111;
			MAIN_SRAM_MODE <= `PWC_SRAM_ACTIVE;
			LOW_POWER_SRAM_MODE <= `PWC_SRAM_ACTIVE;
			BACKUP_RETAIN <= 1'b1;
			PERIPH_CFG_RST <= 1'b0;
			STATE <= ST_FULL;
		end else begin
			CLK_CEIL_MHZ <= ceil_d;
			CLK_SEL_PLL <= pll_d;
			CPU_CLK_EN <= clk_en_d;
			CPU_PWR_EN <= pwr_d;
			HP_PERIPH_PWR <= hp_d;
			ULP_PERIPH_PWR <= ulp_d;
			HS_IF_PWR <= hs_d;
			INSTRUCTION_CACHE_PWR <= ic_d;
			DBG_FPU_ROM_PWR <= dbg_d;
			BATT_PERIPH_PWR <= batt_d;
			ANALOG_PWR <= 1'b1;
			GPIO_EN <= gpio_d;
			MAIN_SRAM_MODE <= main_d;
			LOW_POWER_SRAM_MODE <= lp_d;
			BACKUP_RETAIN <= 1'b1;
			PERIPH_CFG_RST <= cfg_rst_d;
			STATE <= state_d;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (RST) begin
			RDATA <= '0;
		end else if (RD) begin
			unique case (ADDR)
				`PWC_REG_CTRL: RDATA <= {27'h0, sleep_done_q, sup_q, 3'h0};
				`PWC_REG_WAKE_EN: RDATA <= {9'h0, wake_en_q};
				`PWC_REG_STATUS: RDATA <= {15'h0, state_q == ST_RESUME, CLK_CEIL_MHZ,
					4'h0, 4'(state_q)};
				`PWC_REG_CAUSE: RDATA <= {9'h0, cause_q};
				`PWC_REG_LAT: RDATA <= (view == ST_LOW || view == ST_LOW_SB ||
					view == ST_CPU_OFF || view == ST_LOW_SL) ?
					32'(`PWC_LAT_LOW_US) : 32'(`PWC_LAT_FULL_US);
				default: RDATA <= '0;
			endcase
		end else begin
			RDATA <= '0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	reset_full_a: assert property ($fell(RST) |-> state_q == ST_FULL)
		else $error("not full-performance after reset");
	ceil_full_a: assert property (state_q == ST_FULL |=> CLK_CEIL_MHZ == 8'd180 && CLK_SEL_PLL)
		else $error("full-performance ceiling wrong");
	ceil_red_a: assert property (state_q == ST_RED |=> CLK_CEIL_MHZ == 8'd90 && HP_PERIPH_PWR)
		else $error("reduced-voltage ceiling wrong");
	ceil_low_a: assert property (state_q == ST_LOW |=>
		CLK_CEIL_MHZ == ($past(sup_q) ? 8'd32 : 8'd20) && !CLK_SEL_PLL && !HP_PERIPH_PWR)
		else $error("low-voltage ceiling or source wrong");
	off_entry_a: assert property ($rose(state_q == ST_CPU_OFF) |-> $past(state_q) == ST_LOW)
		else $error("processor-off entered from wrong state");
	standby_wait_a: assert property ($rose(state_q == ST_FULL_SB) |->
		$past(WAIT_FOR_INTERRUPT_INSTRUCTION))
		else $error("standby entered without wait-for-interrupt");
	shut_entry_a: assert property ($rose(state_q == ST_SHUT) |-> $past(state_q) == ST_FULL)
		else $error("shutdown entered from wrong state");
	sleep_cfg_a: assert property ($rose(state_q == ST_RESUME) && $past(state_q) != ST_CPU_OFF
		|-> PERIPH_CFG_RST)
		else $error("no configuration reset on sleep exit");
	ulp_ignore_a: assert property (state_q == ST_FULL_SL &&
		(WAKE_SRC & wake_en_q & `PWC_SRC_ALWAYS) == '0 |=> state_q == ST_FULL_SL)
		else $error("low-power wakeup accepted in sleep");
	resume_ret_a: assert property (state_q == ST_RESUME && cnt_q == '0 |=>
		state_q == $past(ret_q) ##1 CPU_CLK_EN)
		else $error("resume did not return to origin");
	cause_latch_a: assert property (hit != '0 |=> (cause_q & $past(hit)) == $past(hit))
		else $error("wakeup cause not latched");

	off_sleep_c: cover property (state_q == ST_CPU_OFF ##1 state_q == ST_LOW_SL);
	shut_wake_c: cover property (state_q == ST_SHUT ##1 state_q == ST_RESUME);
	sb_wake_c: cover property (state_q == ST_RED_SB ##1 state_q == ST_RED);

endmodule

//--- verif/pwc_top_tb.sv
// Self-checking bench for the power-state and wakeup controller
`timescale 1ns/1ps
`include "pwc_defs.svh"

module pwc_top_tb import pwc_pkg::*; ();
	// Short resume counts keep the run brief
	localparam int FULL_N = 8;
	localparam int LOW_N = 4;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic wait_for_interrupt_instruction;
	logic pll, cpu_clk, cpu_pwr, hp, ulp, batt, ana, hs, dbg, instruction_cache, backup, cfg_rst;
	logic [22:0] wake_src;
	logic [7:0] ceil;
	logic [2:0] gpio;
	logic [1:0] main_sram, low_power_sram;
	logic [3:0] state;
	int n_fail = 0;
	int n_tests = 0;
	int n_res = 0;
	int n_cfg = 0;
	int cyc = 0;

	always #4 clk = ~clk;

	// ----------------------------------------
	// Design and partner
	// ----------------------------------------
	pwc_top #(.RESUME_FULL_CYC(FULL_N), .RESUME_LOW_CYC(LOW_N)) i_pwc_top (
		.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.WAIT_FOR_INTERRUPT_INSTRUCTION(wait_for_interrupt_instruction),
		.WAKE_SRC(wake_src), .CLK_CEIL_MHZ(ceil), .CLK_SEL_PLL(pll),
		.CPU_CLK_EN(cpu_clk), .CPU_PWR_EN(cpu_pwr), .HP_PERIPH_PWR(hp), .ULP_PERIPH_PWR(ulp),
		.BATT_PERIPH_PWR(batt), .ANALOG_PWR(ana), .HS_IF_PWR(hs), .DBG_FPU_ROM_PWR(dbg),
		.INSTRUCTION_CACHE_PWR(instruction_cache), .GPIO_EN(gpio), .MAIN_SRAM_MODE(main_sram),
		.LOW_POWER_SRAM_MODE(low_power_sram), .BACKUP_RETAIN(backup), .PERIPH_CFG_RST(cfg_rst),
		.STATE(state)
	);

	pwc_wake_model i_pwc_wake_model (.clk(clk),
		.wait_for_interrupt_instruction(wait_for_interrupt_instruction), .wake_src(wake_src));

	// ----------------------------------------
	// Monitors and helpers
	// ----------------------------------------
	// Counts taken before the edge's updates land, so each counts whole cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (state === ST_RESUME) n_res++;
		if (cfg_rst === 1'b1) n_cfg++;
		if (cyc == 3000) begin
			n_fail++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(what, rdata, exp);
	endtask

	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic wait_st(input logic [3:0] s);
		int i;
		i = 0;
		while (state !== s && i < 100) begin
			@(posedge clk);
			#1;
			i++;
		end
		chk("state", state, s);
	endtask

	// Pll source only matters while the core clock runs
	task automatic chk_pwr(input logic [7:0] c, input logic p, input logic ce,
		input logic pe, input logic h, input logic u, input logic [2:0] g,
		input logic [1:0] ms, input logic [1:0] ls);
		chk("ceil", ceil, c);
		if (ce === 1'b1) chk("pll", pll, p);
		chk("cpu_clk", cpu_clk, ce);
		if (pe !== 1'bx) chk("cpu_pwr", cpu_pwr, pe);
		chk("hp", hp, h);
		chk("ulp", ulp, u);
		chk("gpio", gpio, g);
		chk("main_sram", main_sram, ms);
		chk("low_power_sram", low_power_sram, ls);
		chk("always_on", {batt, ana, backup}, 3'b111);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		settle();
		chk("state", state, ST_FULL);
		chk_pwr(8'd180, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'b111, 2'b10, 2'b10);
		chk("hs_dbg_ic", {hs, dbg, instruction_cache}, 3'b111);
		rd_chk("lat", `PWC_REG_LAT, `PWC_LAT_FULL_US);
		rd_chk("wake_en", `PWC_REG_WAKE_EN, 32'h00000000);
		rd_chk("unmapped", 8'h14, 32'h00000000);
		$display("test reset done");
	endtask

	task automatic t_reduced();
		bus_wr(`PWC_REG_CTRL, 32'h00000002);
		bus_wr(`PWC_REG_WAKE_EN, 32'h00400000);
		settle();
		chk("state", state, ST_RED);
		chk_pwr(8'd90, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'b111, 2'b10, 2'b10);
		i_pwc_wake_model.sleep_core();
		settle();
		chk("state", state, ST_RED_SB);
		chk("cpu_clk", cpu_clk, 1'b0);
		chk("cpu_pwr", cpu_pwr, 1'b1);
		i_pwc_wake_model.raise(22, 5);
		settle();
		chk("state", state, ST_RED);
		chk("cfg_rst", n_cfg, 0);
		i_pwc_wake_model.drop_all();
		rd_chk("cause", `PWC_REG_CAUSE, 32'h00400000);
		bus_wr(`PWC_REG_CAUSE, 32'h007fffff);
		rd_chk("cause", `PWC_REG_CAUSE, 32'h00000000);
		$display("test reduced done");
	endtask

	task automatic t_low();
		bus_wr(`PWC_REG_CTRL, 32'h0000000b);
		settle();
		chk("state", state, ST_LOW);
		chk_pwr(8'd32, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 3'b011, 2'b10, 2'b10);
		chk("hs_if", hs, 1'b0);
		rd_chk("ctrl", `PWC_REG_CTRL, 32'h00000008);
		bus_wr(`PWC_REG_CTRL, 32'h00000000);
		settle();
		chk("ceil", ceil, 8'd20);
		rd_chk("lat", `PWC_REG_LAT, `PWC_LAT_LOW_US);
		bus_wr(`PWC_REG_CTRL, 32'h00000006);
		settle();
		chk("state", state, ST_LOW);
		bus_wr(`PWC_REG_WAKE_EN, 32'h00000400);
		i_pwc_wake_model.sleep_core();
		settle();
		rd_chk("status", `PWC_REG_STATUS, 32'h00001406);
		chk("cpu_clk", cpu_clk, 1'b0);
		i_pwc_wake_model.raise(10, 2);
		wait_st(ST_LOW);
		i_pwc_wake_model.drop_all();
		bus_wr(`PWC_REG_CAUSE, 32'h00000400);
		$display("test low done");
	endtask

	task automatic t_cpu_off();
		bus_wr(`PWC_REG_WAKE_EN, 32'h00000400);
		bus_wr(`PWC_REG_CTRL, 32'h00000005);
		settle();
		chk("state", state, ST_CPU_OFF);
		chk_pwr(8'd0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'b011, 2'b01, 2'b10);
		n_res = 0;
		i_pwc_wake_model.raise(10, 2);
		wait_st(ST_LOW);
		chk("resume", n_res, LOW_N);
		chk("cfg_rst", n_cfg, 0);
		i_pwc_wake_model.drop_all();
		rd_chk("cause", `PWC_REG_CAUSE, 32'h00000400);
		bus_wr(`PWC_REG_CAUSE, 32'h00000400);
		bus_wr(`PWC_REG_CTRL, 32'h00000015);
		i_pwc_wake_model.raise(10, 3);
		settle();
		chk("state", state, ST_LOW_SL);
		chk_pwr(8'd0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'b001, 2'b01, 2'b01);
		rd_chk("lat", `PWC_REG_LAT, `PWC_LAT_LOW_US);
		bus_wr(`PWC_REG_WAKE_EN, 32'h00000401);
		n_res = 0;
		i_pwc_wake_model.raise(0, 1);
		wait_st(ST_LOW);
		chk("resume", n_res, LOW_N);
		chk("cfg_rst", n_cfg, 1);
		i_pwc_wake_model.drop_all();
		rd_chk("cause", `PWC_REG_CAUSE, 32'h00000401);
		bus_wr(`PWC_REG_CAUSE, 32'h00000401);
		$display("test cpu_off done");
	endtask

	task automatic t_sleep();
		bus_wr(`PWC_REG_CTRL, 32'h00000001);
		bus_wr(`PWC_REG_WAKE_EN, 32'h00000401);
		i_pwc_wake_model.sleep_core();
		settle();
		chk("state", state, ST_FULL_SB);
		chk("cpu_clk", cpu_clk, 1'b0);
		i_pwc_wake_model.raise(0, 1);
		wait_st(ST_FULL);
		i_pwc_wake_model.drop_all();
		bus_wr(`PWC_REG_CAUSE, 32'h00000001);
		bus_wr(`PWC_REG_CTRL, 32'h00000004);
		settle();
		chk("state", state, ST_FULL_SL);
		chk_pwr(8'd0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'b001, 2'b01, 2'b01);
		i_pwc_wake_model.raise(10, 1);
		i_pwc_wake_model.raise(1, 1);
		settle();
		chk("state", state, ST_FULL_SL);
		n_res = 0;
		i_pwc_wake_model.raise(0, 3);
		wait_st(ST_FULL);
		chk("resume", n_res, FULL_N);
		chk("cfg_rst", n_cfg, 2);
		i_pwc_wake_model.drop_all();
		rd_chk("cause", `PWC_REG_CAUSE, 32'h00000001);
		bus_wr(`PWC_REG_CAUSE, 32'h00000001);
		$display("test sleep done");
	endtask

	task automatic t_shut();
		bus_wr(`PWC_REG_WAKE_EN, 32'h00000200);
		bus_wr(`PWC_REG_CTRL, 32'h00000006);
		settle();
		chk("state", state, ST_SHUT);
		chk_pwr(8'd0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'b001, 2'b00, 2'b00);
		n_res = 0;
		i_pwc_wake_model.raise(9, 2);
		wait_st(ST_FULL);
		chk("resume", n_res, FULL_N);
		chk("cfg_rst", n_cfg, 3);
		i_pwc_wake_model.drop_all();
		$display("test shutdown done");
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_reduced();
		t_low();
		t_cpu_off();
		t_sleep();
		t_shut();
		end_sim();
	end
endmodule

//--- verif/pwc_wake_model.sv
// Core and wakeup source model on the far side of the power controller
`timescale 1ns/1ps

module pwc_wake_model (
	// Clock
	input wire logic clk,
	// Toward the controller
	output logic wait_for_interrupt_instruction,
	output logic [22:0] wake_src
);
	initial begin
		wait_for_interrupt_instruction = 1'b0;
		wake_src = 23'h000000;
	end

	// Sources are levels held until serviced; a slow source only raises later
	task automatic raise(input int idx, input int dly);
		repeat (dly) @(posedge clk);
		wake_src[idx] <= 1'b1;
	endtask

	task automatic drop_all();
		@(posedge clk);
		wake_src <= 23'h000000;
	endtask

	// One-cycle wait-for-interrupt from the core
	task automatic sleep_core();
		@(posedge clk);
		wait_for_interrupt_instruction <= 1'b1;
		@(posedge clk);
		wait_for_interrupt_instruction <= 1'b0;
	endtask
endmodule
